// [spi_pm_pkg.sv]
package spi_pm_pkg;

  localparam int          CLK_HZ         = 40_000_000;
  localparam int          ADDR_W         = 12;
  localparam int          MODE_W         = 4;
  localparam int          FRAME_BITS     = 48;
  // first address byte whose bits 6:0 are at or above this opens the long form
  localparam logic [6:0]  SHORT_LIMIT    = 7'h70;
  localparam logic [2:0]  LONG_PREFIX    = 3'h7;
  localparam logic [11:0] PWR_REG_ADDR   = 12'h002;
  localparam logic [7:0]  PWR_REG_RESET  = 8'h60;
  localparam int          WAKE_CYCLES_DEF = 64;

  // power_state_select codes
  localparam logic [3:0] PM_RETENTION   = 4'h0;
  localparam logic [3:0] PM_FULL_OFF    = 4'h1;
  localparam logic [3:0] PM_STANDBY     = 4'h5;
  localparam logic [3:0] PM_BUFFER      = 4'h6;
  localparam logic [3:0] PM_SYNTH_RX    = 4'h8;
  localparam logic [3:0] PM_ACTIVE_RX   = 4'h9;
  localparam logic [3:0] PM_WOR_SLEEP   = 4'hB;
  localparam logic [3:0] PM_SYNTH_TX    = 4'hC;
  localparam logic [3:0] PM_ACTIVE_TX   = 4'hD;
  localparam int         LPO_HZ         = 640;

  // timing
  localparam int XTAL_SETTLE_MS   = 3;
  localparam int XTAL_SETTLE_CYC  = XTAL_SETTLE_MS * (CLK_HZ / 1000);
  localparam int SYNTH_SETTLE_CYC = 4000;
  localparam int HALF_DIV_DEF     = 8;

  // host register map (APB byte offsets)
  localparam logic [7:0] HOST_CTRL   = 8'h00;
  localparam logic [7:0] HOST_WDATA  = 8'h04;
  localparam logic [7:0] HOST_STATUS = 8'h08;
  localparam logic [7:0] HOST_RDATA  = 8'h0C;
  localparam int CTRL_WRITE   = 12;
  localparam int CTRL_LONG    = 13;
  localparam int CTRL_LEN_LSB = 14;
  localparam int CTRL_START   = 16;
  localparam int CTRL_WAKE    = 17;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_MISO    = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_CELLS   = 16;

  typedef struct packed {
    logic xoOn;
    logic refOn;
    logic synthOn;
    logic synth_warm_transmit;
    logic rxOn;
    logic txOn;
    logic bufAccess;
    logic bufClear;
    logic lpoOn;
    logic coreOn;
  } power_en_t;

endpackage : spi_pm_pkg

// [spi_link_if.sv]
interface spi_link_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic misoOe;
  logic misoLine;

  // pull-up while the device leaves the line free
  assign misoLine = misoOe ? miso : 1'b1;

  modport device (input sclk, input csN, input mosi, output miso, output misoOe);
  modport host   (output sclk, output csN, output mosi, input misoLine);
endinterface : spi_link_if

// [link_sync.sv]
module link_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // pins in, synchronised out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage_q <= RST_VAL;
      dout    <= RST_VAL;
    end
    else
    begin
      stage_q <= din;
      dout    <= stage_q;
    end
  end

endmodule : link_sync

// [spi_pm_device.sv]
// Notes on behaviour
// - four-wire register link works in every state but full off and waking
// - selected: commands in on mosi, data out
// - address byte with flag, then data bytes
// - flag zero reads, flag one writes
// - addresses below 0x70 use short form
// - address increments after each data byte
// - status bits shift out during address byte
// - cell zero high, low while waking
// - cells one to seven: lock, buffer flags
// - cells eight to fifteen in long form
// - retention sleep keeps registers, cores off
// - retention waits for empty buffer, clears it
// - full off loses all registers
// - select wakes; miso low until ready
// - standby: oscillator on, buffer cleared, waits
// - buffer mode: reference on, buffer kept
// - receive synth warm and active codes
// - wake-on-radio sleep keeps low-power oscillator
// - transmit synth warm and active codes
// - host waits for synth before transmit
// - host session: standby, settle, active, sleep
module spi_pm_device #(
  parameter int REG_COUNT   = 16,
  parameter int WAKE_CYCLES = spi_pm_pkg::WAKE_CYCLES_DEF
)(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // serial link
  spi_link_if.device                       link,
  // radio side
  input  wire logic [1:15]                 radioStatus,
  input  wire logic                        bufEmpty,
  output logic [spi_pm_pkg::MODE_W-1:0]    appliedMode,
  output spi_pm_pkg::power_en_t            powerEn
);
  import spi_pm_pkg::*;

  localparam int               IDX_W   = $clog2(REG_COUNT);
  localparam logic [IDX_W-1:0] PWR_IDX = IDX_W'(PWR_REG_ADDR);

  typedef enum logic [1:0] {PH_ADDR, PH_ADDR2, PH_DATA} phase_t;
  typedef enum logic [1:0] {PW_ON, PW_OFF, PW_WAKE} power_t;

  logic [2:0]        lineSync;
  logic              sclkSync;
  logic              csNSync;
  logic              mosiSync;
  logic              sclkPrev_q;
  logic              csNPrev_q;
  logic              rise;
  logic              fall;
  logic              selected;
  logic              csFall;
  logic              frameOk;
  logic              byteDone;
  logic              wrEn;
  logic              inRange;
  logic [7:0]        inByte;
  logic [7:0]        readData;
  logic [0:15]       cells;
  logic [MODE_W-1:0] requested;

  phase_t            phase_q;
  power_t            powerState_q;
  logic [2:0]        bitCnt_q;
  logic              rdFlag_q;
  logic [ADDR_W-1:0] addr_q;
  logic [6:0]        inShift_q;
  logic [6:0]        outShift_q;
  logic              miso_q;
  logic              misoOe_q;
  logic              wakeFrame_q;
  logic [15:0]       wakeCnt_q;
  logic [MODE_W-1:0] appliedMode_q;
  power_en_t         powerEn_q;
  logic [7:0]        regFile_q [REG_COUNT];

  // pins come from the host's clock domain
  link_sync #(
    .W       (3),
    .RST_VAL (3'h2)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({link.sclk, link.csN, link.mosi}),
    .dout    (lineSync)
  );

  assign {sclkSync, csNSync, mosiSync} = lineSync;
  assign selected = ~csNSync;
  assign rise     = sclkSync & ~sclkPrev_q;
  assign fall     = ~sclkSync & sclkPrev_q;
  assign csFall   = selected & csNPrev_q;
  // frames count in every power state except off and waking
  assign frameOk  = selected & (powerState_q == PW_ON) & ~wakeFrame_q;
  assign inByte   = {inShift_q, mosiSync};
  assign byteDone = frameOk & rise & (bitCnt_q == 3'h7);
  assign wrEn     = byteDone & (phase_q == PH_DATA) & ~rdFlag_q;
  assign inRange  = addr_q < ADDR_W'(REG_COUNT);
  assign readData = inRange ? regFile_q[addr_q[IDX_W-1:0]] : 8'h00;
  assign cells    = {powerState_q == PW_ON, radioStatus};
  assign requested = regFile_q[PWR_IDX][MODE_W-1:0];
  assign link.miso   = miso_q;
  assign link.misoOe = misoOe_q;
  assign appliedMode = appliedMode_q;
  assign powerEn     = powerEn_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclkPrev_q <= 1'b0;
      csNPrev_q  <= 1'b1;
    end
    else
    begin
      sclkPrev_q <= sclkSync;
      csNPrev_q  <= csNSync;
    end
  end

  // frame decode: address byte, optional second address byte, data
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase_q   <= PH_ADDR;
      bitCnt_q  <= 3'h0;
      rdFlag_q  <= 1'b0;
      addr_q    <= '0;
      inShift_q <= 7'h00;
    end
    else if (!frameOk)
    begin
      phase_q  <= PH_ADDR;
      bitCnt_q <= 3'h0;
    end
    else if (rise)
    begin
      inShift_q <= inByte[6:0];
      bitCnt_q  <= bitCnt_q + 3'h1;
      if (bitCnt_q == 3'h7)
      begin
        unique case (phase_q)
          PH_ADDR:
          begin
            rdFlag_q <= ~inByte[7];
            if (inByte[6:0] >= SHORT_LIMIT)
            begin
              phase_q <= PH_ADDR2;
              addr_q  <= {inByte[3:0], 8'h00};
            end
            else
            begin
              phase_q <= PH_DATA;
              addr_q  <= {5'h00, inByte[6:0]};
            end
          end
          PH_ADDR2:
          begin
            phase_q <= PH_DATA;
            addr_q  <= {addr_q[11:8], inByte};
          end
          PH_DATA:
          begin
            addr_q <= addr_q + ADDR_W'(1);
          end
        endcase
      end
    end
  end

  // miso: status during address bytes, then register data on reads and zeros on writes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      miso_q      <= 1'b0;
      misoOe_q    <= 1'b0;
      outShift_q  <= 7'h00;
      wakeFrame_q <= 1'b0;
    end
    else
    begin
      misoOe_q <= selected;
      if (!selected)
      begin
        wakeFrame_q <= 1'b0;
      end
      else if (csFall && powerState_q == PW_OFF)
      begin
        wakeFrame_q <= 1'b1;
      end
      if (wakeFrame_q || powerState_q != PW_ON)
      begin
        miso_q <= (powerState_q == PW_ON) & wakeFrame_q;
      end
      else if (csFall)
      begin
        miso_q     <= cells[0];
        outShift_q <= cells[1:7];
      end
      else if (frameOk && fall && bitCnt_q == 3'h0)
      begin
        if (phase_q == PH_ADDR2)
        begin
          miso_q     <= cells[8];
          outShift_q <= cells[9:15];
        end
        else
        begin
          miso_q     <= rdFlag_q & readData[7];
          outShift_q <= rdFlag_q ? readData[6:0] : 7'h00;
        end
      end
      else if (frameOk && fall)
      begin
        miso_q     <= outShift_q[6];
        outShift_q <= {outShift_q[5:0], 1'b0};
      end
    end
  end

  // register file; contents survive every state but full off
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regFile_q[i] <= (i == int'(PWR_IDX)) ? PWR_REG_RESET : 8'h00;
      end
    end
    else if (powerState_q != PW_ON)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regFile_q[i] <= (i == int'(PWR_IDX)) ? PWR_REG_RESET : 8'h00;
      end
    end
    else if (wrEn && inRange)
    begin
      regFile_q[addr_q[IDX_W-1:0]] <= inByte;
    end
  end

  // power sequencing; retention, standby and wor sleep codes hold off until the buffer drains
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      powerState_q  <= PW_ON;
      appliedMode_q <= PWR_REG_RESET[MODE_W-1:0];
      wakeCnt_q     <= 16'h0000;
    end
    else
    begin
      unique case (powerState_q)
        PW_ON:
        begin
          if (requested == PM_FULL_OFF)
          begin
            powerState_q  <= PW_OFF;
            appliedMode_q <= PM_FULL_OFF;
          end
          else if (!bufEmpty && (requested == PM_RETENTION
                   || requested == PM_STANDBY || requested == PM_WOR_SLEEP))
          begin
            appliedMode_q <= appliedMode_q;
          end
          else
          begin
            appliedMode_q <= requested;
          end
        end
        PW_OFF:
        begin
          if (csFall)
          begin
            powerState_q <= PW_WAKE;
            wakeCnt_q    <= 16'(WAKE_CYCLES - 1);
          end
        end
        PW_WAKE:
        begin
          if (wakeCnt_q == 16'h0000)
          begin
            powerState_q  <= PW_ON;
            appliedMode_q <= PWR_REG_RESET[MODE_W-1:0];
          end
          else
          begin
            wakeCnt_q <= wakeCnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // supply and block enables per applied mode
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      powerEn_q <= '0;
    end
    else
    begin
      powerEn_q        <= '0;
      powerEn_q.coreOn <= 1'b1;
      unique case (appliedMode_q)
        PM_RETENTION:
        begin
          powerEn_q.coreOn   <= 1'b0;
          powerEn_q.bufClear <= 1'b1;
        end
        PM_FULL_OFF:
        begin
          powerEn_q.coreOn   <= 1'b0;
          powerEn_q.bufClear <= 1'b1;
        end
        PM_STANDBY:
        begin
          powerEn_q.xoOn     <= 1'b1;
          powerEn_q.refOn    <= 1'b1;
          powerEn_q.bufClear <= 1'b1;
        end
        PM_BUFFER:
        begin
          powerEn_q.refOn     <= 1'b1;
          powerEn_q.bufAccess <= 1'b1;
        end
        PM_SYNTH_RX, PM_ACTIVE_RX, PM_SYNTH_TX, PM_ACTIVE_TX:
        begin
          powerEn_q.xoOn      <= 1'b1;
          powerEn_q.refOn     <= 1'b1;
          powerEn_q.synthOn   <= 1'b1;
          powerEn_q.bufAccess <= 1'b1;
          powerEn_q.synth_warm_transmit   <= appliedMode_q[2];
          powerEn_q.rxOn      <= appliedMode_q == PM_ACTIVE_RX;
          powerEn_q.txOn      <= appliedMode_q == PM_ACTIVE_TX;
        end
        PM_WOR_SLEEP:
        begin
          powerEn_q.coreOn   <= 1'b0;
          powerEn_q.bufClear <= 1'b1;
          powerEn_q.lpoOn    <= 1'b1;
        end
        default:
        begin
          powerEn_q.coreOn <= 1'b1;
        end
      endcase
    end
  end

endmodule : spi_pm_device

// [spi_pm_host.sv]
module spi_pm_host #(
  parameter int HALF_DIV     = spi_pm_pkg::HALF_DIV_DEF,
  parameter int XTAL_CYC     = spi_pm_pkg::XTAL_SETTLE_CYC,
  parameter int SYNTH_CYC    = spi_pm_pkg::SYNTH_SETTLE_CYC
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  spi_link_if.host         link
);
  import spi_pm_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_HOLD, H_SELECT, H_SHIFT, H_WAKE, H_DONE} host_t;

  host_t                 state_q;
  logic [31:0]           ctrl_q;
  logic [31:0]           wdata_q;
  logic [31:0]           rdata_q;
  logic [15:0]           cells_q;
  logic                  refused_q;
  logic [MODE_W-1:0]     lastMode_q;
  logic [31:0]           settleCnt_q;
  logic [15:0]           divCnt_q;
  logic [FRAME_BITS-1:0] txShift_q;
  logic [FRAME_BITS-1:0] rxBits_q;
  logic [5:0]            bitIdx_q;
  logic                  sclk_q;
  logic                  csN_q;
  logic                  mosi_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  misoSync;
  logic                  tick;
  logic                  apbWr;
  logic                  go;
  logic                  isLong;
  logic                  pwrWrite;
  logic [MODE_W-1:0]     newMode;
  logic [2:0]            byteCount;
  logic [5:0]            bitTotal;
  logic [7:0]            addrByte0;
  logic [31:0]           dataBits;

  link_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (link.misoLine),
    .dout    (misoSync)
  );

  assign link.sclk = sclk_q;
  assign link.csN  = csN_q;
  assign link.mosi = mosi_q;
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = 1'b0;

  assign tick      = divCnt_q == 16'h0000;
  assign apbWr     = psel & penable & pready_q & pwrite;
  assign go        = apbWr & (paddr == HOST_CTRL) & pwdata[CTRL_START] & (state_q == H_IDLE);
  assign isLong    = ctrl_q[CTRL_LONG];
  assign pwrWrite  = ctrl_q[CTRL_WRITE] & ~isLong & (ctrl_q[ADDR_W-1:0] == PWR_REG_ADDR);
  assign newMode   = wdata_q[MODE_W-1:0];
  assign byteCount = 3'h2 + {2'h0, isLong} + {1'h0, ctrl_q[CTRL_LEN_LSB +: 2]};
  assign bitTotal  = {byteCount, 3'h0};
  assign addrByte0 = isLong ? {ctrl_q[CTRL_WRITE], LONG_PREFIX, ctrl_q[11:8]}
                            : {ctrl_q[CTRL_WRITE], ctrl_q[6:0]};
  assign dataBits  = isLong ? rxBits_q[31:0] : rxBits_q[39:8];

  // apb: no wait states, unmapped offsets read zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      ctrl_q   <= 32'h0000_0000;
      wdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= psel & ~penable;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          HOST_CTRL:   prdata_q <= ctrl_q;
          HOST_WDATA:  prdata_q <= wdata_q;
          HOST_STATUS: prdata_q <= {cells_q, 13'h0000, refused_q, misoSync,
                                    state_q != H_IDLE};
          HOST_RDATA:  prdata_q <= rdata_q;
          default:     prdata_q <= 32'h0000_0000;
        endcase
      end
      if (go)
      begin
        ctrl_q <= pwdata & ~(32'h0000_0001 << CTRL_START);
      end
      if (apbWr && paddr == HOST_WDATA && state_q == H_IDLE)
      begin
        wdata_q <= pwdata;
      end
    end
  end

  // settle timers after standby and synth-warm writes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lastMode_q  <= PWR_REG_RESET[MODE_W-1:0];
      settleCnt_q <= 32'h0000_0000;
    end
    else if (state_q == H_DONE && tick && pwrWrite && !ctrl_q[CTRL_WAKE])
    begin
      lastMode_q <= newMode;
      if (newMode == PM_STANDBY)
      begin
        settleCnt_q <= 32'(XTAL_CYC);
      end
      else if (newMode == PM_SYNTH_TX || newMode == PM_SYNTH_RX)
      begin
        settleCnt_q <= 32'(SYNTH_CYC);
      end
      else
      begin
        settleCnt_q <= 32'h0000_0000;
      end
    end
    else if (settleCnt_q != 32'h0000_0000)
    begin
      settleCnt_q <= settleCnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      divCnt_q <= 16'h0000;
    end
    else
    begin
      divCnt_q <= tick ? 16'(HALF_DIV - 1) : divCnt_q - 16'h0001;
    end
  end

  // link sequencer; the host makes the link clock by division
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q   <= H_IDLE;
      sclk_q    <= 1'b0;
      csN_q     <= 1'b1;
      mosi_q    <= 1'b0;
      txShift_q <= '0;
      rxBits_q  <= '0;
      bitIdx_q  <= 6'h00;
      cells_q   <= 16'h0000;
      rdata_q   <= 32'h0000_0000;
      refused_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        H_IDLE:
        begin
          if (go)
          begin
            state_q  <= pwdata[CTRL_WAKE] ? H_WAKE : H_HOLD;
            bitIdx_q <= 6'h00;
          end
        end
        H_HOLD:
        begin
          if (pwrWrite && newMode == PM_ACTIVE_TX && lastMode_q != PM_SYNTH_TX)
          begin
            refused_q <= 1'b1;
            state_q   <= H_IDLE;
          end
          else if (!(pwrWrite && (newMode == PM_ACTIVE_TX || newMode == PM_ACTIVE_RX))
                   || settleCnt_q == 32'h0000_0000)
          begin
            refused_q <= 1'b0;
            txShift_q <= isLong
              ? {addrByte0, ctrl_q[7:0], wdata_q[7:0], wdata_q[15:8],
                 wdata_q[23:16], wdata_q[31:24]}
              : {addrByte0, wdata_q[7:0], wdata_q[15:8], wdata_q[23:16],
                 wdata_q[31:24], 8'h00};
            bitIdx_q  <= 6'h00;
            state_q   <= H_SELECT;
          end
        end
        H_SELECT:
        begin
          csN_q  <= 1'b0;
          mosi_q <= txShift_q[FRAME_BITS-1];
          if (tick && !csN_q)
          begin
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT:
        begin
          if (tick && !sclk_q)
          begin
            sclk_q <= 1'b1;
            rxBits_q[6'(FRAME_BITS - 1) - bitIdx_q] <= misoSync;
            bitIdx_q <= bitIdx_q + 6'h01;
          end
          else if (tick)
          begin
            sclk_q <= 1'b0;
            if (bitIdx_q == bitTotal)
            begin
              state_q <= H_DONE;
            end
            else
            begin
              mosi_q    <= txShift_q[FRAME_BITS-2];
              txShift_q <= {txShift_q[FRAME_BITS-2:0], 1'b0};
            end
          end
        end
        H_WAKE:
        begin
          csN_q <= 1'b0;
          // pull-up reads high until the device drives; poll from the second tick
          if (tick && !csN_q)
          begin
            bitIdx_q <= 6'h01;
          end
          if (!csN_q && misoSync && tick && bitIdx_q != 6'h00)
          begin
            state_q <= H_DONE;
          end
        end
        H_DONE:
        begin
          if (tick)
          begin
            csN_q   <= 1'b1;
            state_q <= H_IDLE;
            if (!ctrl_q[CTRL_WAKE])
            begin
              cells_q <= {rxBits_q[47:40], isLong ? rxBits_q[39:32] : 8'h00};
              rdata_q <= {dataBits[7:0], dataBits[15:8], dataBits[23:16],
                          dataBits[31:24]};
            end
          end
        end
      endcase
    end
  end

endmodule : spi_pm_host

// [spi_link_sva.sv]
module spi_link_sva (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link wires
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       sclkPast_q;
  logic [2:0] bitCnt_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      sclkPast_q <= 1'b0;
    else
      sclkPast_q <= sclk;

  // bits seen since select, modulo one byte
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      bitCnt_q <= 3'h0;
    else if (csN)
      bitCnt_q <= 3'h0;
    else if (sclk && !sclkPast_q)
      bitCnt_q <= bitCnt_q + 3'h1;

  property p_idleClk;
    csN |-> !sclk;
  endproperty
  a_idleClk: assert property (p_idleClk) else $error("clock moved while deselected");
  property p_leadIn;
    $fell(csN) |-> !sclk [*8];
  endproperty
  a_leadIn: assert property (p_leadIn) else $error("clock too soon after select");
  property p_halfHigh;
    $rose(sclk) |-> sclk [*8] ##1 !sclk;
  endproperty
  a_halfHigh: assert property (p_halfHigh) else $error("clock high phase wrong");
  property p_mosiHold;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosiHold: assert property (p_mosiHold) else $error("mosi moved while clock high");
  property p_misoHold;
    sclk && $past(sclk) |-> $stable(miso);
  endproperty
  a_misoHold: assert property (p_misoHold) else $error("miso moved while clock high");
  property p_wholeBytes;
    $rose(csN) |-> bitCnt_q == 3'h0;
  endproperty
  a_wholeBytes: assert property (p_wholeBytes) else $error("frame not whole bytes");
  property p_drive;
    !csN [*8] |-> misoOe;
  endproperty
  a_drive: assert property (p_drive) else $error("miso not driven while selected");
  property p_release;
    csN [*8] |-> !misoOe;
  endproperty
  a_release: assert property (p_release) else $error("miso driven while deselected");
endmodule : spi_link_sva

// [tb_spi_power_mode_port.sv]
module tb_spi_power_mode_port;
  import spi_pm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic [1:15] radioStatus = 15'h5A3C;
  logic        bufEmpty = 1'b0;
  logic [3:0]  appliedMode;
  power_en_t   powerEn;
  int          mismatches = 0;
  int          checksDone = 0;
  logic [3:0]  codes [8] = '{PM_STANDBY, PM_BUFFER, PM_SYNTH_RX, PM_ACTIVE_RX,
                             PM_SYNTH_TX, PM_ACTIVE_TX, PM_WOR_SLEEP, PM_RETENTION};

  always #12.5 clk = ~clk;

  spi_link_if link ();
  spi_pm_device #(.REG_COUNT(16), .WAKE_CYCLES(4)) u_spi_pm_device (.clk(clk),
    .sys_rst(sys_rst), .link(link), .radioStatus(radioStatus), .bufEmpty(bufEmpty),
    .appliedMode(appliedMode), .powerEn(powerEn));
  spi_pm_host #(.HALF_DIV(8), .XTAL_CYC(20), .SYNTH_CYC(10)) u_spi_pm_host (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  spi_link_sva u_spi_link_sva (.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk),
    .csN(link.csN), .mosi(link.mosi), .miso(link.miso), .misoOe(link.misoOe));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic err;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    chk({n < 20, err}, 2'h2);
    if (n >= 20)
      give_verdict();
  endtask : apb

  // one link frame; leaves the final status word in rd
  task automatic xfer(input logic [31:0] ctrl);
    int n;
    apb(1'b1, HOST_CTRL, ctrl | (32'h1 << CTRL_START));
    rd = 32'h1;
    for (n = 0; n < 500 && rd[STAT_BUSY] !== 1'b0; n++)
      apb(1'b0, HOST_STATUS, 32'h0);
    chk(rd[STAT_BUSY], 1'b0);
    if (n >= 500)
      give_verdict();
  endtask : xfer

  task automatic setMode(input logic [3:0] m);
    apb(1'b1, HOST_WDATA, {24'h0, 4'h6, m});
    xfer(32'(PWR_REG_ADDR) | (32'h1 << CTRL_WRITE));
  endtask : setMode

  task automatic waitMode(input logic [3:0] m);
    int n;
    for (n = 0; n < 400 && appliedMode !== m; n++)
      @(posedge clk);
    // enables follow the applied mode one clock later
    @(posedge clk);
    chk(appliedMode, m);
    if (appliedMode !== m)
      give_verdict();
  endtask : waitMode

  // one enable that marks each power state
  function automatic logic [9:0] keyBit(input logic [3:0] m);
    case (m)
      PM_STANDBY:   return 10'h200;
      PM_BUFFER:    return 10'h008;
      PM_SYNTH_RX:  return 10'h080;
      PM_ACTIVE_RX: return 10'h020;
      PM_SYNTH_TX:  return 10'h040;
      PM_ACTIVE_TX: return 10'h010;
      PM_WOR_SLEEP: return 10'h002;
      default:      return 10'h001;
    endcase
  endfunction : keyBit

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    xfer(32'(PWR_REG_ADDR));
    chk(rd[31:16], {1'b1, radioStatus[1:7], 8'h0});
    apb(1'b0, HOST_RDATA, 32'h0);
    chk(rd[7:0], PWR_REG_RESET);
    setMode(PM_STANDBY);
    chk(appliedMode, PM_RETENTION);
    bufEmpty <= 1'b1;
    foreach (codes[i])
    begin
      if (codes[i] == PM_SYNTH_TX)
      begin
        setMode(PM_ACTIVE_TX);
        chk(rd[STAT_REFUSED], 1'b1);
        chk(appliedMode, PM_ACTIVE_RX);
      end
      setMode(codes[i]);
      waitMode(codes[i]);
      chk(powerEn & keyBit(codes[i]),
          (codes[i] == PM_RETENTION) ? 10'h0 : keyBit(codes[i]));
    end
    apb(1'b1, HOST_WDATA, 32'h0000_A55A);
    xfer(32'h3 | (32'h1 << CTRL_WRITE) | (32'h1 << CTRL_LEN_LSB));
    xfer(32'h3 | (32'h1 << CTRL_LONG) | (32'h1 << CTRL_LEN_LSB));
    chk(rd[31:16], {1'b1, radioStatus});
    apb(1'b0, HOST_RDATA, 32'h0);
    chk(rd[15:0], 16'hA55A);
    setMode(PM_FULL_OFF);
    waitMode(PM_FULL_OFF);
    xfer(32'h1 << CTRL_WAKE);
    xfer(32'(PWR_REG_ADDR));
    apb(1'b0, HOST_RDATA, 32'h0);
    chk(rd[7:0], PWR_REG_RESET);
    apb(1'b0, HOST_CTRL, 32'h0);
    chk(rd, 32'(PWR_REG_ADDR));
    apb(1'b0, HOST_WDATA, 32'h0);
    chk(rd, 32'h0000_0061);
    give_verdict();
  end
endmodule : tb_spi_power_mode_port
